// *** core/dbg_bridge.sv ***
/*
 * parallel-to-serial debug bridge: host parallel port handshake, the
 * control/status and data registers, the serial shift engine, soft and
 * hard reset drive and debug-connector status routing.
 * assumes all inputs synchronous to CLOCK_I; two-way pins are split into
 * in/out/enable with enables active low.
 */
`default_nettype none

// Function
// - 8-bit parallel host port, converted to serial in hardware.
// - serial clock made here, independent of the processor clock.
// - cable detached: disable and tri-state all debug outputs.
// - while disabled, route freeze status to the debug connector.
// - respond only when host address equals the three-switch setting.
// - two registers: control/status and data (shift register face).
// - select low picks control/status, high picks data.
// - control/status is eight bits, bit 7 most significant.
// - bit 7 reads high while processor drives soft or hard reset.
// - bit 6 high when last byte was cut by processor reset.
// - bit 5 high while the processor is in debug mode.
// - bits 4-3 pick 10, 5, 2.5 or 1.25 MHz; reset 00. code runs 00 and 01 at 6.25 and 4.17 MHz.
// - bit 2 low makes the board raise its request line; resets low.
// - bit 1 low: serial output tri-stated, bytes looped back; resets low.
// - bit 0 low: processor halts right after soft reset; resets low.
// - both freeze pair lines high means debug mode.
// - drive the active-low hard reset line to hard-reset the processor.
// - full duplex; processor serial output is the ready indication.
// - stay disabled while the host is powered off.
// - host soft reset command while selected soft-resets the processor.

module dbg_bridge
    import dbg_bridge_pkg::*;
(
    // clock and reset
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    // host parallel port
    input wire logic [7:0] HOST_PARALLEL_PORT_I,
    output logic [7:0] HOST_PARALLEL_PORT_O,
    output logic HOST_PARALLEL_PORT_OE_N_O,
    input wire logic HOST_REG_SELECT_I,
    input wire logic HOST_WRITE_I,
    input wire logic HOST_REQUEST_I,
    input wire logic HOST_ACKNOWLEDGE_IN_I,
    input wire logic HOST_SOFT_RESET_CMD_I,
    input wire logic HOST_HARD_RESET_CMD_I,
    input wire logic [2:0] HOST_ADDRESS_I,
    input wire logic [2:0] BOARD_ADDRESS_I,
    input wire logic HOST_POWER_I,
    input wire logic HOST_PRESENT_N_I,
    output logic BOARD_REQUEST_OUT_O,
    output logic BOARD_ACKNOWLEDGE_OUT_O,
    // serial debug link
    output logic SERIAL_DEBUG_CLOCK_O,
    output logic SERIAL_DEBUG_CLOCK_OE_N_O,
    output logic SERIAL_DEBUG_IN_O,
    output logic SERIAL_DEBUG_IN_OE_N_O,
    input wire logic SERIAL_DEBUG_OUT_I,
    // processor status and connector routing
    input wire logic [1:0] FREEZE_STATUS_PAIR_I,
    input wire logic FREEZE_INDICATOR_I,
    input wire logic FREEZE_SOURCE_SEL_I,
    output logic [1:0] CONN_STATUS_O,
    output logic CONN_STATUS_OE_N_O,
    // reset lines
    input wire logic HARD_RESET_LINE_I,
    output logic HARD_RESET_LINE_O,
    output logic HARD_RESET_LINE_OE_N_O,
    input wire logic SOFT_RESET_LINE_I,
    output logic SOFT_RESET_LINE_O,
    output logic SOFT_RESET_LINE_OE_N_O
);

    // *****
    // enable and selection
    // *****
    logic enabled;
    logic selected;

    assign enabled = HOST_POWER_I && !HOST_PRESENT_N_I;
    assign selected = enabled && (HOST_ADDRESS_I == BOARD_ADDRESS_I);

    // *****
    // control/status register
    // *****
    logic [1:0] rate_r;
    logic poll_r;
    logic loop_r;
    logic boot_halt_r;
    logic tgt_reset_r;
    logic send_abort_r;
    logic halted_r;
    logic [7:0] status_word;
    logic ctl_write;

    assign status_word = {tgt_reset_r, send_abort_r, halted_r,
                          rate_r, poll_r, loop_r, boot_halt_r};

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rate_r <= RATE_RESET;
            poll_r <= POLL_RESET;
            loop_r <= LOOP_RESET;
            boot_halt_r <= BOOT_HALT_RESET;
        end else if (ctl_write) begin
            rate_r <= HOST_PARALLEL_PORT_I[RATE_HI_BIT:RATE_LO_BIT];
            poll_r <= HOST_PARALLEL_PORT_I[POLL_BIT];
            loop_r <= HOST_PARALLEL_PORT_I[LOOP_BIT];
            boot_halt_r <= HOST_PARALLEL_PORT_I[BOOT_HALT_BIT];
        end
    end

    // live status, sampled once to keep reads stable
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            tgt_reset_r <= 1'b0;
            halted_r <= 1'b0;
        end else begin
            tgt_reset_r <= !SOFT_RESET_LINE_I || !HARD_RESET_LINE_I;
            halted_r <= FREEZE_SOURCE_SEL_I ? FREEZE_INDICATOR_I
                                            : &FREEZE_STATUS_PAIR_I;
        end
    end

    // *****
    // host handshake
    // *****
    logic buf_in_ready;
    logic data_push;
    logic accept;
    logic [7:0] rx_data_r;

    // a data write waits for buffer room, which stalls the acknowledge
    assign accept = selected && HOST_REQUEST_I && !BOARD_ACKNOWLEDGE_OUT_O
                    && !(HOST_WRITE_I && HOST_REG_SELECT_I && !buf_in_ready);
    assign ctl_write = accept && HOST_WRITE_I && !HOST_REG_SELECT_I;
    assign data_push = accept && HOST_WRITE_I && HOST_REG_SELECT_I;

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            BOARD_ACKNOWLEDGE_OUT_O <= 1'b0;
        end else if (accept) begin
            BOARD_ACKNOWLEDGE_OUT_O <= 1'b1;
        end else if (!HOST_REQUEST_I || !selected) begin
            BOARD_ACKNOWLEDGE_OUT_O <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            HOST_PARALLEL_PORT_O <= 8'h00;
            HOST_PARALLEL_PORT_OE_N_O <= 1'b1;
        end else if (accept && !HOST_WRITE_I) begin
            HOST_PARALLEL_PORT_O <= HOST_REG_SELECT_I ? rx_data_r : status_word;
            HOST_PARALLEL_PORT_OE_N_O <= 1'b0;
        end else if (!HOST_REQUEST_I || !selected) begin
            HOST_PARALLEL_PORT_OE_N_O <= 1'b1;
        end
    end

    // *****
    // transmit buffer
    // *****
    logic buf_valid;
    logic buf_pop;
    logic [7:0] buf_data;

    dbg_byte_buffer #(
        .WIDTH(BYTE_BITS),
        .DEPTH(2)
    ) u_tx_buf (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .in_valid_i(data_push),
        .in_ready_o(buf_in_ready),
        .in_data_i(HOST_PARALLEL_PORT_I),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_pop),
        .out_data_o(buf_data)
    );

    // *****
    // reset sequencing
    // *****
    logic [5:0] srst_cnt_r;
    logic [5:0] cfg_cnt_r;
    logic [5:0] hrst_cnt_r;
    logic cfg_active;

    assign cfg_active = (srst_cnt_r != 6'h00) || (cfg_cnt_r != 6'h00);

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            srst_cnt_r <= 6'h00;
            cfg_cnt_r <= 6'h00;
        end else if (selected && HOST_SOFT_RESET_CMD_I && !cfg_active) begin
            srst_cnt_r <= RESET_PULSE_CYC;
        end else if (srst_cnt_r != 6'h00) begin
            srst_cnt_r <= srst_cnt_r - 6'h01;
            // configuration must outlast the rising edge
            if (srst_cnt_r == 6'h01) begin
                cfg_cnt_r <= CFG_HOLD_CYC;
            end
        end else if (cfg_cnt_r != 6'h00) begin
            cfg_cnt_r <= cfg_cnt_r - 6'h01;
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            hrst_cnt_r <= 6'h00;
        end else if (selected && HOST_HARD_RESET_CMD_I && hrst_cnt_r == 6'h00) begin
            hrst_cnt_r <= RESET_PULSE_CYC;
        end else if (hrst_cnt_r != 6'h00) begin
            hrst_cnt_r <= hrst_cnt_r - 6'h01;
        end
    end

    // open drain: only ever pull low
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            SOFT_RESET_LINE_O <= 1'b0;
            SOFT_RESET_LINE_OE_N_O <= 1'b1;
            HARD_RESET_LINE_O <= 1'b0;
            HARD_RESET_LINE_OE_N_O <= 1'b1;
        end else begin
            SOFT_RESET_LINE_OE_N_O <= !(enabled && srst_cnt_r != 6'h00);
            HARD_RESET_LINE_OE_N_O <= !(enabled && hrst_cnt_r != 6'h00);
        end
    end

    // *****
    // serial shift engine
    // *****
    shift_state_e state_r;
    logic [7:0] tx_sh_r;
    logic [7:0] rx_sh_r;
    logic [2:0] bit_cnt_r;
    logic abort_seen_r;
    logic sclk_r;
    logic sdata_r;
    logic tick;
    logic link_ready;
    logic rx_bit;
    logic poll_event;

    // processor holds its output low when able to take a byte
    assign link_ready = loop_r ? !SERIAL_DEBUG_OUT_I : 1'b1;
    assign rx_bit = loop_r ? SERIAL_DEBUG_OUT_I : sdata_r;
    assign buf_pop = (state_r == SH_IDLE) && buf_valid && enabled
                     && link_ready && !cfg_active;

    dbg_rate_gen u_rate (
        .clk_i(CLOCK_I),
        .rst_i(RESET_I),
        .run_i(state_r == SH_LOW || state_r == SH_HIGH),
        .rate_i(rate_r),
        .tick_o(tick)
    );

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state_r <= SH_IDLE;
            tx_sh_r <= 8'h00;
            rx_sh_r <= 8'h00;
            bit_cnt_r <= 3'h0;
            sclk_r <= 1'b0;
            sdata_r <= 1'b0;
        end else begin
            unique case (state_r)
                SH_IDLE: begin
                    sclk_r <= 1'b0;
                    if (buf_pop) begin
                        tx_sh_r <= {buf_data[6:0], 1'b0};
                        sdata_r <= buf_data[7];
                        bit_cnt_r <= 3'h0;
                        state_r <= SH_LOW;
                    end
                end
                SH_LOW: begin
                    if (tick) begin
                        sclk_r <= 1'b1;
                        rx_sh_r <= {rx_sh_r[6:0], rx_bit};
                        state_r <= SH_HIGH;
                    end
                end
                SH_HIGH: begin
                    if (tick) begin
                        sclk_r <= 1'b0;
                        // data moves only on the falling edge
                        sdata_r <= tx_sh_r[7];
                        tx_sh_r <= {tx_sh_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                        state_r <= (bit_cnt_r == 3'(BYTE_BITS - 1)) ? SH_DONE : SH_LOW;
                    end
                end
                SH_DONE: begin
                    state_r <= SH_IDLE;
                end
            endcase
        end
    end

    // abort watch restarts with every byte
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            abort_seen_r <= 1'b0;
            send_abort_r <= 1'b0;
            rx_data_r <= 8'h00;
        end else if (buf_pop) begin
            abort_seen_r <= 1'b0;
        end else if (state_r == SH_DONE) begin
            send_abort_r <= abort_seen_r;
            rx_data_r <= rx_sh_r;
        end else if (state_r != SH_IDLE && tgt_reset_r) begin
            abort_seen_r <= 1'b1;
        end
    end

    // *****
    // board request to host
    // *****
    assign poll_event = (state_r == SH_DONE) && !poll_r;

    // a new event beats the host's acknowledge in the same cycle
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            BOARD_REQUEST_OUT_O <= 1'b0;
        end else if (poll_event) begin
            BOARD_REQUEST_OUT_O <= 1'b1;
        end else if (HOST_ACKNOWLEDGE_IN_I || poll_r) begin
            BOARD_REQUEST_OUT_O <= 1'b0;
        end
    end

    // *****
    // link pin drive
    // *****
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            SERIAL_DEBUG_CLOCK_O <= 1'b0;
            SERIAL_DEBUG_CLOCK_OE_N_O <= 1'b1;
            SERIAL_DEBUG_IN_O <= 1'b0;
            SERIAL_DEBUG_IN_OE_N_O <= 1'b1;
        end else if (!enabled) begin
            SERIAL_DEBUG_CLOCK_OE_N_O <= 1'b1;
            SERIAL_DEBUG_IN_OE_N_O <= 1'b1;
        end else if (cfg_active) begin
            // clock high through the edge asks for halt at boot
            SERIAL_DEBUG_CLOCK_O <= !boot_halt_r;
            SERIAL_DEBUG_IN_O <= 1'b0;
            SERIAL_DEBUG_CLOCK_OE_N_O <= 1'b0;
            SERIAL_DEBUG_IN_OE_N_O <= 1'b0;
        end else begin
            SERIAL_DEBUG_CLOCK_O <= sclk_r;
            SERIAL_DEBUG_IN_O <= sdata_r;
            SERIAL_DEBUG_CLOCK_OE_N_O <= 1'b0;
            SERIAL_DEBUG_IN_OE_N_O <= !loop_r;
        end
    end

    // external tool sees run status only while we are off the link
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            CONN_STATUS_O <= 2'h0;
            CONN_STATUS_OE_N_O <= 1'b1;
        end else begin
            CONN_STATUS_O <= FREEZE_SOURCE_SEL_I ? {2{FREEZE_INDICATOR_I}}
                                                 : FREEZE_STATUS_PAIR_I;
            CONN_STATUS_OE_N_O <= enabled;
        end
    end

endmodule : dbg_bridge

`default_nettype wire

// *** core/dbg_bridge_pkg.sv ***
/*
 * constants shared by the parallel-to-serial debug bridge: control/status
 * field positions, reset values, state encodings and timing counts.
 * assumes a 25 MHz interface clock.
 */
`default_nettype none

package dbg_bridge_pkg;

    // *****
    // clock
    // *****
    localparam int CLK_PERIOD_NS = 40;

    // *****
    // control/status field positions
    // *****
    localparam int TGT_RESET_BIT = 7;
    localparam int SEND_ABORT_BIT = 6;
    localparam int HALTED_BIT = 5;
    localparam int RATE_HI_BIT = 4;
    localparam int RATE_LO_BIT = 3;
    localparam int POLL_BIT = 2;
    localparam int LOOP_BIT = 1;
    localparam int BOOT_HALT_BIT = 0;

    // *****
    // reset values (all control bits wake active)
    // *****
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic POLL_RESET = 1'b0;
    localparam logic LOOP_RESET = 1'b0;
    localparam logic BOOT_HALT_RESET = 1'b0;

    // *****
    // serial clock half periods, per rate code
    // *****
    localparam int HALF_10M_NS = 50;
    localparam int HALF_5M_NS = 100;
    localparam int HALF_2M5_NS = 200;
    localparam int HALF_1M25_NS = 400;
    // shortest period is a floor on time, so round up
    localparam logic [3:0] HALF_10M_CYC = 4'((HALF_10M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HALF_5M_CYC = 4'((HALF_5M_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HALF_2M5_CYC = 4'((HALF_2M5_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [3:0] HALF_1M25_CYC = 4'((HALF_1M25_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // *****
    // reset sequencing
    // *****
    localparam int RESET_PULSE_NS = 1000;
    localparam int CFG_HOLD_NS = 800;
    localparam logic [5:0] RESET_PULSE_CYC = 6'((RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [5:0] CFG_HOLD_CYC = 6'((CFG_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam int BYTE_BITS = 8;

    // *****
    // serial engine states
    // *****
    typedef enum logic [1:0] {
        SH_IDLE = 2'h0,
        SH_LOW = 2'h1,
        SH_HIGH = 2'h3,
        SH_DONE = 2'h2
    } shift_state_e;

endpackage : dbg_bridge_pkg

`default_nettype wire

// *** core/dbg_byte_buffer.sv ***
/*
 * two-entry byte buffer with valid/ready on both sides.
 * assumes one clock and an asynchronous active-high reset.
 */
`default_nettype none

module dbg_byte_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] rd_ptr_r;
    logic [PW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_o = (count_r != (PW + 1)'(DEPTH));
    assign out_valid_o = (count_r != '0);
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

endmodule : dbg_byte_buffer

`default_nettype wire

// *** core/dbg_rate_gen.sv ***
/*
 * serial clock half-period tick generator, rate picked by a 2-bit code.
 * assumes the 25 MHz interface clock; ticks only while run_i is high.
 */
`default_nettype none

module dbg_rate_gen
    import dbg_bridge_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic run_i,
    input wire logic [1:0] rate_i,
    // one-cycle tick per half period
    output logic tick_o
);
    logic [3:0] cnt_r;
    logic [3:0] half;

    always_comb begin
        unique case (rate_i)
            2'h0: half = HALF_10M_CYC;
            2'h1: half = HALF_5M_CYC;
            2'h2: half = HALF_2M5_CYC;
            2'h3: half = HALF_1M25_CYC;
        endcase
    end

    // restarts on every run so the first half period is whole
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 4'h0;
            tick_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r <= 4'h0;
            tick_o <= 1'b0;
        end else if (cnt_r >= half - 4'h1) begin
            cnt_r <= 4'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            tick_o <= 1'b0;
        end
    end

endmodule : dbg_rate_gen

`default_nettype wire

// *** sim/dbg_bridge_props.sv ***
/* port checks on dbg_bridge.
   assumes one clock and an async active-high reset. */
`default_nettype none
module dbg_bridge_props (
    // host side
    input wire logic CLOCK_I,
    input wire logic RESET_I,
    input wire logic HOST_REQUEST_I,
    input wire logic HOST_WRITE_I,
    input wire logic HOST_POWER_I,
    input wire logic HOST_PRESENT_N_I,
    input wire logic [2:0] HOST_ADDRESS_I,
    input wire logic [2:0] BOARD_ADDRESS_I,
    input wire logic BOARD_ACKNOWLEDGE_OUT_O,
    input wire logic HOST_PARALLEL_PORT_OE_N_O,
    // link side
    input wire logic SERIAL_DEBUG_CLOCK_O,
    input wire logic SERIAL_DEBUG_CLOCK_OE_N_O,
    input wire logic SERIAL_DEBUG_IN_O,
    input wire logic SERIAL_DEBUG_IN_OE_N_O,
    input wire logic CONN_STATUS_OE_N_O,
    input wire logic HARD_RESET_LINE_OE_N_O,
    input wire logic SOFT_RESET_LINE_OE_N_O,
    input wire logic SOFT_RESET_LINE_I
);
    wire logic sel = HOST_POWER_I & !HOST_PRESENT_N_I & (HOST_ADDRESS_I == BOARD_ADDRESS_I);
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    chk_read_ack_next: assert property (sel && HOST_REQUEST_I && !HOST_WRITE_I
        && !BOARD_ACKNOWLEDGE_OUT_O |=> BOARD_ACKNOWLEDGE_OUT_O && !HOST_PARALLEL_PORT_OE_N_O)
        else $error("read not answered next cycle");
    chk_unsel_no_ack: assert property (!sel |=> !BOARD_ACKNOWLEDGE_OUT_O)
        else $error("ack while not selected");
    chk_idle_no_drive: assert property ((HOST_WRITE_I || !HOST_REQUEST_I) [*2] |->
        HOST_PARALLEL_PORT_OE_N_O) else $error("host port driven outside read");
    chk_detach_tristate: assert property (HOST_PRESENT_N_I [*2] |->
        SERIAL_DEBUG_CLOCK_OE_N_O && SERIAL_DEBUG_IN_OE_N_O) else $error("link driven detached");
    chk_power_off_route: assert property (!HOST_POWER_I [*2] |-> !CONN_STATUS_OE_N_O)
        else $error("status not routed while off");
    chk_hard_pull_held: assert property ($fell(HARD_RESET_LINE_OE_N_O) |->
        !HARD_RESET_LINE_OE_N_O [*8]) else $error("hard reset pulse short");
    chk_soft_pull_held: assert property ($fell(SOFT_RESET_LINE_OE_N_O) |->
        !SOFT_RESET_LINE_OE_N_O [*8]) else $error("soft reset pulse short");
    chk_sclk_half_min: assert property ($rose(SERIAL_DEBUG_CLOCK_O) |->
        SERIAL_DEBUG_CLOCK_O [*2]) else $error("serial clock high too short");
    chk_data_at_fall: assert property ($rose(SERIAL_DEBUG_CLOCK_O) && SOFT_RESET_LINE_I
        && SOFT_RESET_LINE_OE_N_O |-> $stable(SERIAL_DEBUG_IN_O)) else $error("data moved on rise");
endmodule : dbg_bridge_props
bind dbg_bridge dbg_bridge_props i_dbg_bridge_props (.*);
`default_nettype wire

// *** sim/dbg_bridge_tb.sv ***
/* self-checking bench for dbg_bridge, host tasks plus random bytes.
   assumes dbg_proc_model on the link and the bound checker. */
`default_nettype none
module dbg_bridge_tb;
    import dbg_bridge_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLOCK_I = 0, RESET_I = 1, HOST_REG_SELECT_I = 0, HOST_WRITE_I = 0, HOST_REQUEST_I = 0;
    logic HOST_ACKNOWLEDGE_IN_I = 0, HOST_SOFT_RESET_CMD_I = 0, HOST_HARD_RESET_CMD_I = 0;
    logic HOST_POWER_I = 1, HOST_PRESENT_N_I = 0, FREEZE_INDICATOR_I = 0, FREEZE_SOURCE_SEL_I = 0;
    logic busy = 1, prst = 0, HOST_PARALLEL_PORT_OE_N_O, BOARD_REQUEST_OUT_O, SERIAL_DEBUG_OUT_I;
    logic BOARD_ACKNOWLEDGE_OUT_O, SERIAL_DEBUG_CLOCK_O, SERIAL_DEBUG_CLOCK_OE_N_O;
    logic SERIAL_DEBUG_IN_O, SERIAL_DEBUG_IN_OE_N_O, CONN_STATUS_OE_N_O, HARD_RESET_LINE_O;
    logic HARD_RESET_LINE_OE_N_O, SOFT_RESET_LINE_O, SOFT_RESET_LINE_OE_N_O;
    logic [7:0] HOST_PARALLEL_PORT_I = 8'h00, HOST_PARALLEL_PORT_O, rep = 8'h00, mrx, q, h;
    logic [2:0] HOST_ADDRESS_I = 3'h5, BOARD_ADDRESS_I = 3'h5;
    logic [1:0] FREEZE_STATUS_PAIR_I = 2'h0, CONN_STATUS_O;
    logic [3:0] hx [4] = '{HALF_10M_CYC, HALF_5M_CYC, HALF_2M5_CYC, HALF_1M25_CYC};
    logic [19:0] s = 20'h1_69E3;
    int err_total = 0, n_tests = 0;
    // reset lines float up when released, link lines are pulled down
    wire HARD_RESET_LINE_I = HARD_RESET_LINE_OE_N_O | HARD_RESET_LINE_O;
    wire SOFT_RESET_LINE_I = (SOFT_RESET_LINE_OE_N_O | SOFT_RESET_LINE_O) & !prst;
    wire sck = !SERIAL_DEBUG_CLOCK_OE_N_O & SERIAL_DEBUG_CLOCK_O;
    wire sdi = !SERIAL_DEBUG_IN_OE_N_O & SERIAL_DEBUG_IN_O;
    dbg_bridge i_dbg_bridge (.*);
    dbg_proc_model i_dbg_proc_model (.sck_i(sck), .sdi_i(sdi), .sdo_o(SERIAL_DEBUG_OUT_I),
        .busy_i(busy), .reply_i(rep), .rx_o(mrx));
    initial forever #(CLK_PERIOD_NS / 2) CLOCK_I = ~CLOCK_I;
    function automatic logic [19:0] lf(input logic [19:0] v);
        lf = {v[18:0], v[19] ^ v[16]};
    endfunction : lf
    function automatic logic [7:0] st(input logic [7:0] c);
        st = {!(HARD_RESET_LINE_I & SOFT_RESET_LINE_I), 1'b0, &FREEZE_STATUS_PAIR_I, c[4:0]};
    endfunction : st
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge CLOCK_I);
        #1;
    endtask : tk
    task automatic go(input logic rs, input logic w, input logic [7:0] d);
        HOST_REG_SELECT_I = rs;
        HOST_WRITE_I = w;
        HOST_PARALLEL_PORT_I = w ? d : ~HOST_PARALLEL_PORT_I;
        HOST_REQUEST_I = 1'b1;
    endtask : go
    // ack is registered, so a falling edge sees it settled
    task automatic fin();
        int n;
        n = 0;
        while (BOARD_ACKNOWLEDGE_OUT_O !== 1'b1 && n < 3000) begin
            @(negedge CLOCK_I);
            n++;
        end
        q = HOST_PARALLEL_PORT_O;
        tk(1);
        HOST_REQUEST_I = 1'b0;
        while (BOARD_ACKNOWLEDGE_OUT_O !== 1'b0 && n < 3100) begin
            @(negedge CLOCK_I);
            n++;
        end
        chk(8'(n < 3000), 8'h01);
        tk(1);
    endtask : fin
    task automatic acc(input logic rs, input logic w, input logic [7:0] d);
        go(rs, w, d);
        fin();
    endtask : acc
    task automatic give_verdict();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #(CLK_PERIOD_NS * 20000);
        err_total++;
        give_verdict();
    end
    initial begin
        tk(10);
        RESET_I = 1'b0;
        tk(1);
        acc(1'b0, 1'b0, 8'h00);
        chk(q, st(8'h00));
        for (int r = 0; r < 4; r++) begin
            s = lf(lf(s));
            acc(1'b0, 1'b1, {s[7:5], 2'(r), 3'h0});
            acc(1'b0, 1'b0, 8'h00);
            chk(q, st({3'h0, 2'(r), 3'h0}));
            acc(1'b1, 1'b1, s[15:8]);
            h = 8'h00;
            for (int i = 0; i < 900 && !sck; i++) tk(1);
            while (sck && h < 8'hC8) begin
                h++;
                tk(1);
            end
            chk(h, {4'h0, hx[r]});
            tk(300);
            chk({6'h00, SERIAL_DEBUG_IN_OE_N_O, BOARD_REQUEST_OUT_O}, 8'h03);
            HOST_ACKNOWLEDGE_IN_I = 1'b1;
            tk(1);
            HOST_ACKNOWLEDGE_IN_I = 1'b0;
            tk(1);
            chk(8'(BOARD_REQUEST_OUT_O), 8'h00);
            acc(1'b1, 1'b0, 8'h00);
            chk(q, s[15:8]);
        end
        s = lf(s);
        rep = {1'b0, s[6:0]};
        acc(1'b0, 1'b1, 8'h06);
        acc(1'b1, 1'b1, 8'hA5);
        acc(1'b1, 1'b1, 8'h3C);
        go(1'b1, 1'b1, s[19:12]);
        tk(20);
        chk({6'h00, BOARD_ACKNOWLEDGE_OUT_O, sck}, 8'h00);
        busy = 1'b0;
        fin();
        tk(400);
        chk(mrx, s[19:12]);
        acc(1'b1, 1'b0, 8'h00);
        chk(q, rep);
        acc(1'b1, 1'b1, 8'h81);
        tk(12);
        prst = 1'b1;
        tk(3);
        prst = 1'b0;
        tk(100);
        acc(1'b0, 1'b0, 8'h00);
        chk(q & 8'h40, 8'h40);
        acc(1'b1, 1'b1, 8'h18);
        tk(100);
        for (int i = 0; i < 4; i++) begin
            FREEZE_STATUS_PAIR_I = 2'(i);
            tk(2);
            acc(1'b0, 1'b0, 8'h00);
            chk(q, st(8'h06));
        end
        HOST_SOFT_RESET_CMD_I = 1'b1;
        tk(2);
        HOST_SOFT_RESET_CMD_I = 1'b0;
        tk(3);
        chk({5'h00, SOFT_RESET_LINE_OE_N_O, sck, sdi}, 8'h02);
        acc(1'b0, 1'b0, 8'h00);
        chk(q & 8'h80, 8'h80);
        HOST_HARD_RESET_CMD_I = 1'b1;
        tk(2);
        HOST_HARD_RESET_CMD_I = 1'b0;
        tk(3);
        chk(8'(HARD_RESET_LINE_OE_N_O), 8'h00);
        tk(60);
        chk({6'h00, HARD_RESET_LINE_OE_N_O, SOFT_RESET_LINE_OE_N_O}, 8'h03);
        HOST_ADDRESS_I = 3'h2;
        go(1'b0, 1'b0, 8'h00);
        tk(10);
        chk(8'(BOARD_ACKNOWLEDGE_OUT_O), 8'h00);
        HOST_REQUEST_I = 1'b0;
        {HOST_PRESENT_N_I, FREEZE_SOURCE_SEL_I, FREEZE_INDICATOR_I} = 3'h7;
        tk(3);
        chk({4'h0, SERIAL_DEBUG_CLOCK_OE_N_O, CONN_STATUS_OE_N_O, CONN_STATUS_O}, 8'h0B);
        {HOST_PRESENT_N_I, HOST_POWER_I, HOST_ADDRESS_I} = 5'h05;
        tk(3);
        chk({6'h00, CONN_STATUS_OE_N_O, SERIAL_DEBUG_IN_OE_N_O}, 8'h01);
        give_verdict();
    end
endmodule : dbg_bridge_tb
`default_nettype wire

// *** sim/dbg_proc_model.sv ***
/* processor end of the serial debug link, behavioural.
   assumes pulled-down clock and data, clock low between frames. */
`default_nettype none
module dbg_proc_model (
    // serial link
    input wire logic sck_i,
    input wire logic sdi_i,
    output logic sdo_o,
    // bench control
    input wire logic busy_i,
    input wire logic [7:0] reply_i,
    output logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_r = 8'h00;
    logic [7:0] in_r = 8'h00;
    logic [2:0] cnt_r = 3'h0;
    // high reads as not ready, so a stall is just busy_i
    assign sdo_o = busy_i | sh_r[7];
    assign rx_o = in_r;
    always @(posedge sck_i) begin
        in_r <= {in_r[6:0], sdi_i};
        cnt_r <= cnt_r + 3'h1;
    end
    // reload only on a frame boundary; top bit doubles as ready
    always @(negedge sck_i) begin
        sh_r <= (cnt_r == 3'h0) ? reply_i : {sh_r[6:0], 1'b0};
    end
endmodule : dbg_proc_model
`default_nettype wire
